// ==== rtl/ctl_port_pkg.sv ====
// constants for the three-wire control write port
`default_nettype none
package ctl_port_pkg;
  localparam int FRAME_BITS = 14;          // r/w + address + payload
  localparam int ADDR_W = 3;               // word_select_field width
  localparam int DATA_W = 10;              // word_payload_field width
  localparam int NUM_WORDS = 8;            // control words
  localparam logic [2:0] WORD_SYS = 3'h0;  // standby, mode, sat bits
  localparam logic [2:0] WORD_TX = 3'h1;   // holds speaker route field
  localparam logic [2:0] WORD_RX = 3'h4;   // trim, source, volume
  localparam logic [2:0] WORD_TEST = 3'h5; // holds the test mode code
  localparam logic [9:0] WORD_RESET = 10'h000; // every word after reset
  localparam logic [3:0] CNT_LAST = 4'hE;  // rising edges in a full frame
  localparam logic [3:0] CNT_RD = 4'h4;    // rises taken before read-back starts
  // field positions
  localparam int STANDBY_SELECT_BIT_POS = 9;
  localparam int MODE_HI = 8;
  localparam int MODE_LO = 7;
  localparam int SAT_SOURCE_BIT_POS = 6;
  localparam int SAT_COMPARATOR_BYPASS_BIT_POS = 5;
  localparam int LS_HI = 1;
  localparam int LS_LO = 0;
  localparam int RXT_HI = 9;
  localparam int RXT_LO = 6;
  localparam int RECEIVE_SOURCE_SELECT_HI = 5;
  localparam int RECEIVE_SOURCE_SELECT_LO = 4;
  localparam int VOL_HI = 3;
  localparam int VOL_LO = 0;
  localparam int TEST_HI = 1;
  localparam int TEST_LO = 0;
endpackage : ctl_port_pkg
`default_nettype wire

// ==== rtl/sync_two_ff.sv ====
// two-flop synchroniser for one level from outside the clock domain
`default_nettype none
module sync_two_ff (
  input wire logic clock,   // block clock
  input wire logic rst,     // synchronous reset, active high
  input wire logic din,     // asynchronous level
  input wire logic init,    // value held during reset
  output logic dout         // synchronised level
);
  logic meta_ff; // first stage, read only by second stage
  // plain double register; reset value keeps idle line levels
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= init;
      dout <= init;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule : sync_two_ff
`default_nettype wire

// ==== rtl/ctl_write_port.sv ====
// three-wire serial control write port with control word storage
`default_nettype none
module ctl_write_port (
  input wire logic clock,                 // 25 MHz block clock
  input wire logic rst,                   // synchronous reset, active high
  input wire logic serial_shift_clock,    // host serial clock pin
  input wire logic select_n,              // host chip select, active low
  input wire logic data_in,               // data line input side
  output logic data_out,                  // data line output side
  output logic data_oe,                   // data line enable, high drives
  input wire logic [7:0] conv_result,     // converter result for read-back
  output logic conv_clock_en,             // pulse per serial clock rise
  output logic active_mode,               // 1 active, 0 standby
  output logic [1:0] system_mode,         // system mode select
  output logic sat_source_bit,            // 1 filter, 0 external pin
  output logic sat_comparator_bypass_bit, // 1 bypass comparator
  output logic [1:0] speaker_route_field, // speaker drive select
  output logic [3:0] receive_trim_field,  // receive gain trim
  output logic [1:0] receive_source_select, // volume stage input
  output logic [3:0] volume_field,        // volume level
  output logic [1:0] test_field,          // test mode code
  output logic trim_stage_en,             // gain trim stage enable
  output logic data_detect_en,            // data comparator enable
  output logic voice_path_en,             // voice and transmit enable
  output logic fast_data_rate,            // 1 for 10 kbit/s, 0 for 8 kbit/s
  output logic [2:0] last_word,           // address of last update
  output logic word_written               // one-cycle pulse on update
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,   // deselected
    ST_SHIFT = 3'b010,  // taking bits
    ST_DONE = 3'b100    // frame complete, ignore edges
  } frame_e;
  frame_e state_ff; // frame state
  logic sclk_s;     // synchronised serial clock
  logic sel_s;      // synchronised chip select, active high
  logic din_s;      // synchronised data
  logic sclk_d_ff;  // previous serial clock level
  logic [3:0] cnt_ff; // rising edges taken
  logic [13:0] shift_ff; // input shift register
  logic [9:0] words_ff [ctl_port_pkg::NUM_WORDS]; // control words
  logic [7:0] rd_ff; // read-back shift register
  logic rise;  // serial clock rising edge
  logic fall;  // serial clock falling edge
  logic sel;   // selected
  logic commit; // register update strobe
  logic [2:0] waddr; // update address

  // synchronisers: the serial pins are far slower than the block clock
  sync_two_ff u_sclk (.clock(clock), .rst(rst), .din(serial_shift_clock), .init(1'b0),
                      .dout(sclk_s));
  sync_two_ff u_sel (.clock(clock), .rst(rst), .din(~select_n), .init(1'b0), .dout(sel_s));
  sync_two_ff u_din (.clock(clock), .rst(rst), .din(data_in), .init(1'b0), .dout(din_s));

  assign sel = sel_s;
  assign rise = sclk_s & ~sclk_d_ff;
  assign fall = ~sclk_s & sclk_d_ff;
  assign waddr = shift_ff[12:10];
  // write frames only: a cleared first bit is a read request
  assign commit = sel && state_ff == ST_SHIFT && fall && cnt_ff == ctl_port_pkg::CNT_LAST
                  && shift_ff[13];

  // edge detector history
  always_ff @(posedge clock) begin
    if (rst) sclk_d_ff <= 1'b0;
    else sclk_d_ff <= sclk_s;
  end

  // frame sequencing
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
    end else if (!sel) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          // one idle cycle after select; the host waits far longer before its first rise
          state_ff <= ST_SHIFT;
          cnt_ff <= 4'h0;
        end
        ST_SHIFT: begin
          // the count stops at a full frame so later rises cannot wrap it
          if (rise && cnt_ff != ctl_port_pkg::CNT_LAST) cnt_ff <= cnt_ff + 4'h1;
          if (fall && cnt_ff == ctl_port_pkg::CNT_LAST) state_ff <= ST_DONE;
        end
        ST_DONE: state_ff <= ST_DONE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // serial shift, msb first
  always_ff @(posedge clock) begin
    if (rst || !sel) shift_ff <= 14'h0000;
    else if (state_ff == ST_SHIFT && rise && cnt_ff != ctl_port_pkg::CNT_LAST)
      shift_ff <= {shift_ff[12:0], din_s};
  end

  // control word storage; all ten bits load in one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < ctl_port_pkg::NUM_WORDS; i++) words_ff[i] <= ctl_port_pkg::WORD_RESET;
    end else if (commit) begin
      // the address field picks the word; all ten bits move together
      words_ff[waddr] <= shift_ff[9:0];
    end
  end

  // update report
  always_ff @(posedge clock) begin
    if (rst) begin
      word_written <= 1'b0;
      last_word <= 3'h0;
    end else begin
      word_written <= commit;
      if (commit) last_word <= waddr;
    end
  end

  // read-back: a frame with the first bit clear returns the converter byte
  always_ff @(posedge clock) begin
    if (rst || !sel) begin
      rd_ff <= 8'h00;
      data_oe <= 1'b0;
      data_out <= 1'b0;
    end else if (state_ff == ST_SHIFT && fall && cnt_ff == ctl_port_pkg::CNT_RD
                 && !shift_ff[3]) begin
      // read frame: the first shifted bit is still clear after the fourth rise
      rd_ff <= {conv_result[6:0], 1'b0};
      data_out <= conv_result[7];
      data_oe <= 1'b1;
    end else if (data_oe && fall && state_ff == ST_SHIFT) begin
      // each later fall moves the next bit out; zeros follow the byte
      data_out <= rd_ff[7];
      rd_ff <= {rd_ff[6:0], 1'b0};
    end
  end

  // converter clock enable rides on the host serial clock
  always_ff @(posedge clock) begin
    if (rst) conv_clock_en <= 1'b0;
    else conv_clock_en <= rise;
  end

  // decoded controls
  always_comb begin
    active_mode = words_ff[ctl_port_pkg::WORD_SYS][ctl_port_pkg::STANDBY_SELECT_BIT_POS];
    system_mode = words_ff[ctl_port_pkg::WORD_SYS][ctl_port_pkg::MODE_HI:ctl_port_pkg::MODE_LO];
    sat_source_bit = words_ff[ctl_port_pkg::WORD_SYS][ctl_port_pkg::SAT_SOURCE_BIT_POS];
    sat_comparator_bypass_bit = words_ff[ctl_port_pkg::WORD_SYS][ctl_port_pkg::SAT_COMPARATOR_BYPASS_BIT_POS];
    speaker_route_field = words_ff[ctl_port_pkg::WORD_TX][ctl_port_pkg::LS_HI:ctl_port_pkg::LS_LO];
    receive_trim_field = words_ff[ctl_port_pkg::WORD_RX][ctl_port_pkg::RXT_HI:ctl_port_pkg::RXT_LO];
    receive_source_select =
      words_ff[ctl_port_pkg::WORD_RX][ctl_port_pkg::RECEIVE_SOURCE_SELECT_HI:ctl_port_pkg::RECEIVE_SOURCE_SELECT_LO];
    volume_field = words_ff[ctl_port_pkg::WORD_RX][ctl_port_pkg::VOL_HI:ctl_port_pkg::VOL_LO];
    // test code is reachable only through a serial write to its word
    test_field =
      words_ff[ctl_port_pkg::WORD_TEST][ctl_port_pkg::TEST_HI:ctl_port_pkg::TEST_LO];
    trim_stage_en = 1'b1;
    data_detect_en = 1'b1;
    voice_path_en = active_mode;
    fast_data_rate = (system_mode == 2'b00);
  end

  // checks
  // an update pulse always follows a commit taken while selected
  a_commit_needs_sel: assert property (@(posedge clock) disable iff (rst)
    word_written |-> $past(sel)) else $error("update without select");
  // the update report is a single-cycle pulse
  a_one_per_frame: assert property (@(posedge clock) disable iff (rst)
    word_written |-> ##1 !word_written) else $error("double update");
  // the addressed word takes all ten shifted bits in one step
  a_update_lands: assert property (@(posedge clock) disable iff (rst)
    commit |=> words_ff[$past(waddr)] == $past(shift_ff[9:0])) else $error("word lost");
  // only the fourteenth falling edge may commit
  a_full_count: assert property (@(posedge clock) disable iff (rst)
    commit |-> cnt_ff == ctl_port_pkg::CNT_LAST) else $error("short frame committed");
  // the rise counter saturates at a full frame
  a_count_bound: assert property (@(posedge clock) disable iff (rst)
    cnt_ff <= ctl_port_pkg::CNT_LAST) else $error("count overrun");
  // deselect clears the counter and the shifter in the next cycle
  a_drop_clears: assert property (@(posedge clock) disable iff (rst)
    !sel |=> cnt_ff == 4'h0 && shift_ff == 14'h0000) else $error("no reset on deselect");
  // standby leaves trim and data detection on, voice path off
  a_standby_rx: assert property (@(posedge clock) disable iff (rst)
    !active_mode |-> data_detect_en && trim_stage_en && !voice_path_en)
    else $error("standby path wrong");
  // the data rate follows the mode field
  a_rate_mode: assert property (@(posedge clock) disable iff (rst)
    fast_data_rate == (system_mode == 2'b00)) else $error("rate mismatch");
  // the shared line is driven only inside a selected frame
  a_idle_no_drive: assert property (@(posedge clock) disable iff (rst)
    !sel |=> !data_oe) else $error("line driven while deselected");
  // a read frame puts the converter msb out at the fourth fall
  a_readback_start: assert property (@(posedge clock) disable iff (rst)
    sel && state_ff == ST_SHIFT && fall && cnt_ff == ctl_port_pkg::CNT_RD && !shift_ff[3]
    |=> data_oe && data_out == $past(conv_result[7])) else $error("read-back did not start");
  // a finished frame stays closed while select is held
  a_done_holds: assert property (@(posedge clock) disable iff (rst)
    sel && state_ff == ST_DONE |=> state_ff == ST_DONE && !word_written)
    else $error("frame reopened while selected");
endmodule : ctl_write_port
`default_nettype wire

// ==== sim/host_model.sv ====
// host model: drives serial clock, chip select and host side of the data line
`default_nettype none
module host_model (
  input wire logic clock, // block clock, paces the serial pins
  input wire logic data_line, // shared data line as the host sees it
  output logic serial_shift_clock, // host serial clock, low outside frames
  output logic select_n, // chip select, active low
  output logic host_data, // host drive onto the shared data line
  output logic [13:0] heard // line level at each of the first fourteen rises
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: deselected, serial clock parked low
  initial begin
    serial_shift_clock = 1'b0;
    select_n = 1'b1;
    host_data = 1'b0;
    heard = 14'h0000;
  end
  // half a 320 ns serial period is four block clocks
  task automatic half_period();
    repeat (4) @(negedge clock);
  endtask : half_period
  // one framed message, msb first; pulses past the fourteenth toggle the line
  task automatic frame(input logic [13:0] bits, input int pulses);
    select_n = 1'b0;
    heard = 14'h0000;
    half_period();
    for (int i = 0; i < pulses; i++) begin
      host_data = (i < 14) ? bits[13 - i] : ~host_data;
      half_period();
      serial_shift_clock = 1'b1;
      if (i < 14) heard[13 - i] = data_line;
      half_period();
      serial_shift_clock = 1'b0;
    end
    half_period();
    select_n = 1'b1;
    host_data = ~host_data; // released line no longer shows the last bit
    repeat (6) @(negedge clock);
  endtask : frame
endmodule : host_model
`default_nettype wire

// ==== sim/ctl_write_port_tb_top.sv ====
// testbench top for the three-wire control write port
`default_nettype none
module ctl_write_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst, sclk, select_n, host_data, data_line, data_out, data_oe;
  logic [7:0] conv_result;
  logic conv_clock_en, active_mode, sat_src, sat_byp, trim_en, detect_en, voice_en, fast_rate;
  logic [1:0] system_mode, speaker, rx_src, test_field;
  logic [3:0] trim, volume;
  logic [2:0] last_word;
  logic word_written;
  logic [12:0] expq[$]; // expected {address, payload} per committed frame
  logic [13:0] heard; // host's view of the line at each rise
  int fail_count = 0;
  int total_checks = 0;
  int rises = 0;
  logic [12:0] note;
  assign data_line = data_oe ? data_out : host_data;
  host_model i_host (.clock(clock), .data_line(data_line), .serial_shift_clock(sclk),
    .select_n(select_n), .host_data(host_data), .heard(heard));
  ctl_write_port i_dut (.clock(clock), .rst(rst), .serial_shift_clock(sclk),
    .select_n(select_n), .data_in(data_line), .data_out(data_out), .data_oe(data_oe),
    .conv_result(conv_result), .conv_clock_en(conv_clock_en), .active_mode(active_mode),
    .system_mode(system_mode), .sat_source_bit(sat_src), .sat_comparator_bypass_bit(sat_byp),
    .speaker_route_field(speaker), .receive_trim_field(trim), .receive_source_select(rx_src),
    .volume_field(volume), .test_field(test_field), .trim_stage_en(trim_en),
    .data_detect_en(detect_en), .voice_path_en(voice_en), .fast_data_rate(fast_rate),
    .last_word(last_word), .word_written(word_written));
  // 25 MHz block clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // field outputs reassembled into their word layout; unmapped bits read 0
  function automatic logic [9:0] seen(input logic [2:0] a);
    case (a)
      3'h0: seen = {active_mode, system_mode, sat_src, sat_byp, 5'h00};
      3'h1: seen = {8'h00, speaker};
      3'h4: seen = {trim, rx_src, volume};
      3'h5: seen = {8'h00, test_field};
      default: seen = 10'h000;
    endcase
  endfunction : seen
  function automatic logic [9:0] keep(input logic [2:0] a);
    case (a)
      3'h0: keep = 10'h3E0;
      3'h1, 3'h5: keep = 10'h003;
      3'h4: keep = 10'h3FF;
      default: keep = 10'h000;
    endcase
  endfunction : keep
  // watcher: every update pulse consumes the oldest note
  always @(posedge clock) begin
    if (conv_clock_en === 1'b1) rises++;
    if (rst === 1'b0 && word_written !== 1'b0) begin
      if (expq.size() == 0) begin
        check(1'b0, "update with no complete write frame");
      end else begin
        note = expq.pop_front();
        check(last_word === note[12:10], "wrong word address");
        check(seen(note[12:10]) === (note[9:0] & keep(note[12:10])), "word fields");
        if (note[12:10] == 3'h0) begin
          check(voice_en === note[9], "standby path enable");
          check(fast_rate === (note[8:7] == 2'h0), "data rate select");
        end
      end
      check(trim_en === 1'b1 && detect_en === 1'b1, "standby-proof enables");
    end
  end
  // send a frame, count serial rises, confirm the update landed
  task automatic send(input logic [13:0] bits, input int pulses);
    if (bits[13] && pulses >= ctl_port_pkg::FRAME_BITS) expq.push_back(bits[12:0]);
    rises = 0;
    i_host.frame(bits, pulses);
    check(rises == pulses, "converter clock pulse count");
    check(expq.size() == 0, "update missing within frame tail");
    if (bits[13] && pulses >= ctl_port_pkg::FRAME_BITS)
      check(heard === bits, "data line not left to the host");
    if (!bits[13]) check(heard[9:2] === conv_result, "read-back byte");
  endtask : send
  initial begin
    rst = 1'b1;
    conv_result = 8'h00;
    void'($urandom(36));
    repeat (16) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    for (int i = 0; i < 4; i++) begin
      send({4'hC, 4'($urandom), 2'(i), 4'($urandom)}, 14);
      send({4'h9, 8'($urandom), 2'(i)}, 14);
      send({4'h8, i[0], i[1], 1'b0, i[1], ~i[0], 5'($urandom)}, 14);
    end
    send({4'h9, 10'h3FF}, 13);
    send({4'h9, 10'h2A5}, 14);
    send({4'hC, 10'h3FE}, 17);
    conv_result = 8'($urandom);
    send({4'h1, 10'h155}, 14);
    send({4'hB, 10'($urandom)}, 14);
    send({4'hD, 10'($urandom)}, 14);
    end_of_test();
  end
endmodule : ctl_write_port_tb_top
`default_nettype wire
